// ---- phy_port_map.svh ----
// offsets, field positions, reset values for the port-2 phy control/status registers
`ifndef PHY_PORT_MAP_SVH
`define PHY_PORT_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CABLE_DIAG_CTRL_OFS 8'h2a
`define CABLE_FAULT_DIST_LOW_OFS 8'h2b
`define PHY_NEG_CTRL_OFS 8'h2c
`define PHY_PORT_CTRL_OFS 8'h2d
`define PHY_LINK_STATE_OFS 8'h2e
// ----------------------------------------
// cable diagnostic control fields
// ----------------------------------------
`define DIAG_SHORT_BIT 7
`define DIAG_RESULT_HI 6
`define DIAG_RESULT_LO 5
`define DIAG_EN_BIT 4
`define DIAG_FORCE_LINK_BIT 3
`define DIAG_RSVD_BIT 2
`define DIAG_REMOTE_LB_BIT 1
`define DIAG_DIST_MSB_BIT 0
// ----------------------------------------
// negotiation control fields
// ----------------------------------------
`define NEG_AN_EN_BIT 7
`define NEG_SPEED_BIT 6
`define NEG_DUPLEX_BIT 5
`define NEG_STRAP_LO 5
`define NEG_ADV_HI 4
`define NEG_ADV_LO 0
// ----------------------------------------
// port control fields
// ----------------------------------------
`define PORT_LED_OFF_BIT 7
`define PORT_TXDIS_BIT 6
`define PORT_RESTART_BIT 5
`define PORT_FEF_DIS_BIT 4
`define PORT_PWRDN_BIT 3
`define PORT_MDIX_DIS_BIT 2
`define PORT_FORCE_MDI_BIT 1
`define PORT_LOOPBACK_BIT 0
// ----------------------------------------
// link state fields
// ----------------------------------------
`define STATE_MDI_BIT 7
`define STATE_AN_DONE_BIT 6
// ----------------------------------------
// reset values
// ----------------------------------------
`define NEG_CTRL_RST 8'hff
`define PORT_CTRL_RST 8'h00
`define DIAG_RSVD_RST 1'b1
`define FAULT_DIST_RST 9'h000
`define STRAP_DEFAULT 3'h7
`define STRAP_FILL_CYCLES 2'h2
`endif

// ---- phy_port_types_pkg.sv ----
// types shared by the port phy control/status register block
`default_nettype none
package phy_port_types_pkg;
  typedef enum logic [1:0] {
    CABLE_NORMAL = 2'b00,
    CABLE_OPEN = 2'b01,
    CABLE_SHORT = 2'b10,
    CABLE_TEST_FAILED = 2'b11
  } cable_result_t;
  typedef enum logic {
    DIAG_IDLE = 1'b0,
    DIAG_RUN = 1'b1
  } diag_state_t;
endpackage
`default_nettype wire

// ---- phy_port_control_status_regs.sv ----
// port-2 phy control and status registers with cable test sequencing and strap capture
`default_nettype none
`include "phy_port_map.svh"

//
// Contract
// - fault distance is 9 bits read-only: msb in diag reg bit 0, low byte separate
// - distance is about 0.4 m per count; the count resets to zero
// - negotiation bit 7 on enables negotiation; off uses bits 6 and 5
// - enable, speed and duplex reset from strap pins, nominal value one
// - with negotiation off, bit 6 forces 100 when 1, 10 when 0
// - bit 5 forces full/half duplex when negotiation off or failed
// - bits 4..0 advertise pause, 100 full/half, 10 full/half; all reset to one
// - led-off bit drives both port indicator pins high
// - port control bit 6 disables the transmitter
// - writing one to port control bit 5 restarts negotiation
// - port control bit 4 disables far-end fault detection and pattern sending
// - port control bit 2 disables automatic crossover
// - crossover off: bit 1 forces mdi when 1, mdi-x when 0
// - port control bit 0 loops port 1 traffic through port 2 pmd/pma
// - link state bit 6 reads one once negotiation completed, resets zero
// - software sets diag enable; device clears it when done; results then valid
// - cable outcome: 00 normal, 01 open, 10 short, 11 test failed
module phy_port_control_status_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // strap pins
  input wire logic strap_port2_negotiate,
  input wire logic strap_port2_speed,
  input wire logic strap_port2_duplex,
  // cable tester
  output logic cable_test_start,
  input wire logic cable_test_done,
  input wire logic [1:0] cable_test_result,
  input wire logic cable_test_short_10m,
  input wire logic [8:0] cable_test_distance,
  // negotiation engine
  output logic an_enable,
  output logic [4:0] an_advertise,
  output logic an_restart,
  input wire logic an_complete,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  output logic link_speed_100,
  output logic link_full_duplex,
  // crossover
  output logic mdix_auto_disable,
  output logic force_mdi,
  input wire logic mdix_resolved_mdi,
  // port controls
  output logic tx_disable,
  output logic power_down,
  output logic far_end_fault_disable,
  output logic loopback,
  output logic remote_loopback,
  output logic force_link,
  // indicators, active-low pins
  input wire logic led_one_drive_n,
  input wire logic led_zero_drive_n,
  output logic port_indicator_pin_one,
  output logic port_indicator_pin_zero
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] neg_ctrl_ff;
  logic [7:0] port_ctrl_ff;
  logic diag_en_ff;
  logic force_link_ff;
  logic remote_lb_ff;
  phy_port_types_pkg::cable_result_t cable_result_ff;
  logic cable_short_ff;
  logic [8:0] fault_dist_ff;
  phy_port_types_pkg::diag_state_t diag_state_ff;
  phy_port_types_pkg::diag_state_t nxt_diag_state;
  logic test_start_ff;
  logic restart_ff;
  logic an_done_ff;
  logic mdi_state_ff;
  logic speed_ff;
  logic duplex_ff;
  logic led_one_ff;
  logic led_zero_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [2:0] strap_s1_ff;
  logic [2:0] strap_s2_ff;
  logic [2:0] strap_s3_ff;
  logic strap_taken_ff;
  logic [1:0] strap_fill_ff;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire wr_diag = reg_wr && addr_hit(reg_addr, `CABLE_DIAG_CTRL_OFS);
  wire wr_neg = reg_wr && addr_hit(reg_addr, `PHY_NEG_CTRL_OFS);
  wire wr_port = reg_wr && addr_hit(reg_addr, `PHY_PORT_CTRL_OFS);
  wire start_req = wr_diag && reg_wdata[`DIAG_EN_BIT];
  wire restart_req = wr_port && reg_wdata[`PORT_RESTART_BIT];
  // a change on the straps counts only once the last two stages agree
  wire strap_stable = strap_s2_ff == strap_s3_ff;
  // the reset fill of the stages is no pin level, so compare only once pins have reached stage 2
  wire strap_filled = strap_fill_ff == `STRAP_FILL_CYCLES;
  wire strap_load = strap_filled && !strap_taken_ff && strap_stable;

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // async reset cannot load a pin level, so the straps are caught
  // in the first settled cycle after release instead
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_s1_ff <= `STRAP_DEFAULT;
      strap_s2_ff <= `STRAP_DEFAULT;
      strap_s3_ff <= `STRAP_DEFAULT;
      strap_taken_ff <= 1'b0;
      strap_fill_ff <= 2'h0;
    end else begin
      strap_s1_ff <= {strap_port2_negotiate, strap_port2_speed, strap_port2_duplex};
      strap_s2_ff <= strap_s1_ff;
      strap_s3_ff <= strap_s2_ff;
      if (!strap_filled) begin
        strap_fill_ff <= strap_fill_ff + 2'h1;
      end
      if (strap_load) begin
        strap_taken_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // negotiation control
  // ----------------------------------------
  // a software write in the capture cycle wins over the strap value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      neg_ctrl_ff <= `NEG_CTRL_RST;
    end else if (wr_neg) begin
      neg_ctrl_ff <= reg_wdata;
    end else if (strap_load) begin
      neg_ctrl_ff[`NEG_AN_EN_BIT:`NEG_STRAP_LO] <= strap_s3_ff;
    end
  end

  // ----------------------------------------
  // port control
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_ctrl_ff <= `PORT_CTRL_RST;
    end else if (wr_port) begin
      port_ctrl_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= restart_req;
    end
  end

  // ----------------------------------------
  // cable diagnostic sequencing
  // ----------------------------------------
  // a start is only taken while idle; a start bit written during a run is ignored
  always_comb begin
    nxt_diag_state = diag_state_ff;
    unique case (diag_state_ff)
      phy_port_types_pkg::DIAG_IDLE: begin
        if (start_req) begin
          nxt_diag_state = phy_port_types_pkg::DIAG_RUN;
        end
      end
      phy_port_types_pkg::DIAG_RUN: begin
        if (cable_test_done) begin
          nxt_diag_state = phy_port_types_pkg::DIAG_IDLE;
        end
      end
    endcase
  end

  wire diag_launch = diag_state_ff == phy_port_types_pkg::DIAG_IDLE && start_req;
  wire diag_finish = diag_state_ff == phy_port_types_pkg::DIAG_RUN && cable_test_done;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      diag_state_ff <= phy_port_types_pkg::DIAG_IDLE;
      diag_en_ff <= 1'b0;
      test_start_ff <= 1'b0;
    end else begin
      diag_state_ff <= nxt_diag_state;
      test_start_ff <= diag_launch;
      if (diag_launch) begin
        diag_en_ff <= 1'b1;
      end else if (diag_finish) begin
        diag_en_ff <= 1'b0;
      end
    end
  end

  // results change only at the end of a run, so a zero enable bit
  // always pairs with a settled result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cable_result_ff <= phy_port_types_pkg::CABLE_NORMAL;
      cable_short_ff <= 1'b0;
      fault_dist_ff <= `FAULT_DIST_RST;
    end else if (diag_finish) begin
      cable_result_ff <= phy_port_types_pkg::cable_result_t'(cable_test_result);
      cable_short_ff <= cable_test_short_10m;
      fault_dist_ff <= cable_test_distance;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      force_link_ff <= 1'b0;
      remote_lb_ff <= 1'b0;
    end else if (wr_diag) begin
      force_link_ff <= reg_wdata[`DIAG_FORCE_LINK_BIT];
      remote_lb_ff <= reg_wdata[`DIAG_REMOTE_LB_BIT];
    end
  end

  // ----------------------------------------
  // link resolution
  // ----------------------------------------
  wire an_on = neg_ctrl_ff[`NEG_AN_EN_BIT];
  // negotiated speed comes from the engine, forced speed from bit 6
  wire nxt_speed = an_on ? an_speed_100 : neg_ctrl_ff[`NEG_SPEED_BIT];
  // an unfinished negotiation falls back to the forced duplex
  wire nxt_duplex = (an_on && an_complete) ? an_full_duplex
                                           : neg_ctrl_ff[`NEG_DUPLEX_BIT];
  wire nxt_mdi = port_ctrl_ff[`PORT_MDIX_DIS_BIT] ? port_ctrl_ff[`PORT_FORCE_MDI_BIT]
                                                  : mdix_resolved_mdi;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_ff <= 1'b0;
      duplex_ff <= 1'b0;
      an_done_ff <= 1'b0;
      mdi_state_ff <= 1'b0;
    end else begin
      speed_ff <= nxt_speed;
      duplex_ff <= nxt_duplex;
      an_done_ff <= an_on && an_complete;
      mdi_state_ff <= nxt_mdi;
    end
  end

  // ----------------------------------------
  // indicators
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_one_ff <= 1'b1;
      led_zero_ff <= 1'b1;
    end else begin
      led_one_ff <= port_ctrl_ff[`PORT_LED_OFF_BIT] | led_one_drive_n;
      led_zero_ff <= port_ctrl_ff[`PORT_LED_OFF_BIT] | led_zero_drive_n;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  wire [7:0] diag_word = {cable_short_ff, cable_result_ff, diag_en_ff, force_link_ff,
                          `DIAG_RSVD_RST, remote_lb_ff, fault_dist_ff[8]};
  wire [7:0] state_word = {mdi_state_ff, an_done_ff, 6'h00};
  wire [7:0] rd_mux =
    addr_hit(reg_addr, `CABLE_DIAG_CTRL_OFS) ? diag_word :
    addr_hit(reg_addr, `CABLE_FAULT_DIST_LOW_OFS) ? fault_dist_ff[7:0] :
    addr_hit(reg_addr, `PHY_NEG_CTRL_OFS) ? neg_ctrl_ff :
    addr_hit(reg_addr, `PHY_PORT_CTRL_OFS) ? port_ctrl_ff :
    addr_hit(reg_addr, `PHY_LINK_STATE_OFS) ? state_word : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      if (reg_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign cable_test_start = test_start_ff;
  assign an_enable = neg_ctrl_ff[`NEG_AN_EN_BIT];
  assign an_advertise = neg_ctrl_ff[`NEG_ADV_HI:`NEG_ADV_LO];
  assign an_restart = restart_ff;
  assign link_speed_100 = speed_ff;
  assign link_full_duplex = duplex_ff;
  assign mdix_auto_disable = port_ctrl_ff[`PORT_MDIX_DIS_BIT];
  assign force_mdi = port_ctrl_ff[`PORT_FORCE_MDI_BIT];
  assign tx_disable = port_ctrl_ff[`PORT_TXDIS_BIT];
  assign power_down = port_ctrl_ff[`PORT_PWRDN_BIT];
  assign far_end_fault_disable = port_ctrl_ff[`PORT_FEF_DIS_BIT];
  assign loopback = port_ctrl_ff[`PORT_LOOPBACK_BIT];
  assign remote_loopback = remote_lb_ff;
  assign force_link = force_link_ff;
  assign port_indicator_pin_one = led_one_ff;
  assign port_indicator_pin_zero = led_zero_ff;

endmodule // phy_port_control_status_regs
`default_nettype wire

// ---- phy_port_regs_chk.sv ----
// assertion checker for the port phy control/status registers
`default_nettype none
`include "phy_port_map.svh"
module phy_port_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  // phy side
  input wire logic cable_test_start,
  input wire logic an_enable,
  input wire logic [4:0] an_advertise,
  input wire logic an_restart,
  input wire logic an_complete,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic link_speed_100,
  input wire logic link_full_duplex,
  input wire logic tx_disable,
  input wire logic power_down,
  input wire logic far_end_fault_disable,
  input wire logic mdix_auto_disable,
  input wire logic force_mdi,
  input wire logic loopback,
  input wire logic port_indicator_pin_one,
  input wire logic port_indicator_pin_zero
);
  timeunit 1ns;
  timeprecision 1ns;
  wire wr_neg = reg_wr && reg_addr == `PHY_NEG_CTRL_OFS;
  wire wr_port = reg_wr && reg_addr == `PHY_PORT_CTRL_OFS;
  wire diag_go = reg_wr && reg_addr == `CABLE_DIAG_CTRL_OFS && reg_wdata[`DIAG_EN_BIT];
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  read_answer_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after request");
  port_fields_a: assert property (wr_port |=>
    {tx_disable, far_end_fault_disable, power_down, mdix_auto_disable, force_mdi, loopback} ==
    {$past(reg_wdata[6]), $past(reg_wdata[4:0])})
    else $error("port control outputs differ from written value");
  neg_fields_a: assert property (wr_neg |=> {an_enable, an_advertise} ==
    {$past(reg_wdata[7]), $past(reg_wdata[4:0])}) else $error("negotiation outputs differ from write");
  restart_pulse_a: assert property (wr_port && reg_wdata[5] |=> an_restart)
    else $error("restart write gave no restart pulse");
  test_cause_a: assert property (cable_test_start |-> $past(diag_go))
    else $error("cable test started without a launch write");
  test_single_a: assert property (cable_test_start |=> !cable_test_start)
    else $error("cable test start longer than one cycle");
  speed_follow_a: assert property (an_enable |=> link_speed_100 == $past(an_speed_100))
    else $error("negotiated speed not passed on");
  duplex_follow_a: assert property (an_enable && an_complete |=>
    link_full_duplex == $past(an_full_duplex))
    else $error("negotiated duplex not passed on");
  led_off_a: assert property (wr_port && reg_wdata[7] |->
    ##2 port_indicator_pin_one && port_indicator_pin_zero)
    else $error("indicator pins not driven high");
endmodule // phy_port_chk
bind phy_port_control_status_regs phy_port_chk u_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rvalid, .cable_test_start, .an_enable, .an_advertise, .an_restart, .an_complete, .an_speed_100,
  .an_full_duplex, .link_speed_100, .link_full_duplex, .tx_disable, .power_down, .far_end_fault_disable,
  .mdix_auto_disable, .force_mdi, .loopback, .port_indicator_pin_one, .port_indicator_pin_zero);
`default_nettype wire

// ---- phy_far_side.sv ----
// far-side model: cable tester and negotiation engine behind the register block
`default_nettype none
module phy_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // requests and bench setup
  input wire logic cable_test_start,
  input wire logic an_restart,
  input wire logic [3:0] set_delay,
  input wire logic [11:0] set_cable,
  input wire logic an_fail,
  // answers
  output logic cable_test_done,
  output logic [1:0] cable_test_result,
  output logic cable_test_short_10m,
  output logic [8:0] cable_test_distance,
  output logic an_complete
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] run_ff;
  logic [4:0] an_ff;
  // data is only true in the done cycle; a capture at any other edge sees the inverse
  assign {cable_test_short_10m, cable_test_result, cable_test_distance} = cable_test_done ? set_cable : ~set_cable;
  assign an_complete = an_ff == 5'h00 && !an_fail;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_ff <= 4'h0;
      an_ff <= 5'h14;
      cable_test_done <= 1'b0;
    end else begin
      cable_test_done <= run_ff == 4'h1;
      run_ff <= cable_test_start ? set_delay : run_ff - {3'h0, run_ff != 4'h0};
      an_ff <= an_restart ? 5'h14 : an_ff - {4'h0, an_ff != 5'h00};
    end
  end
endmodule // phy_far_side
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the port phy control/status registers
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, reg_wr, reg_rd, reg_rvalid, an_speed_100, an_full_duplex, mdix_resolved_mdi, an_fail;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, neg, pc;
  logic [2:0] strap;
  logic [1:0] led_n;
  logic [3:0] set_delay;
  logic [11:0] set_cable;
  wire cable_test_start, cable_test_done, cable_test_short_10m, an_enable, an_restart, an_complete;
  wire link_speed_100, link_full_duplex, mdix_auto_disable, force_mdi, tx_disable, power_down;
  wire far_end_fault_disable, loopback, pin_one, pin_zero, remote_loopback, force_link;
  wire [1:0] cable_test_result;
  wire [8:0] cable_test_distance;
  wire [4:0] an_advertise;
  integer seed, mismatches, compares, cycles, starts, i, n;
  phy_port_control_status_regs u_dut (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .strap_port2_negotiate(strap[2]), .strap_port2_speed(strap[1]), .strap_port2_duplex(strap[0]),
    .cable_test_start, .cable_test_done, .cable_test_result, .cable_test_short_10m, .cable_test_distance,
    .an_enable, .an_advertise, .an_restart, .an_complete, .an_speed_100, .an_full_duplex, .link_speed_100,
    .link_full_duplex, .mdix_auto_disable, .force_mdi, .mdix_resolved_mdi, .tx_disable, .power_down,
    .far_end_fault_disable, .loopback, .remote_loopback, .force_link, .led_one_drive_n(led_n[1]),
    .led_zero_drive_n(led_n[0]), .port_indicator_pin_one(pin_one), .port_indicator_pin_zero(pin_zero));
  phy_far_side u_far (.clk, .rst, .cable_test_start, .an_restart, .set_delay, .set_cable, .an_fail,
    .cable_test_done, .cable_test_result, .cable_test_short_10m, .cable_test_distance, .an_complete);
  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    starts = starts + (cable_test_start === 1'b1);
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      test_done();
    end
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = dt;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask
  function automatic logic [1:0] exp_link(input logic [7:0] nc, input logic done, input logic spd, input logic fd);
    exp_link = {nc[7] ? spd : nc[6], (nc[7] && done) ? fd : nc[5]};
  endfunction
  function automatic logic [7:0] exp_state(input logic [7:0] nc, input logic [7:0] p, input logic done, input logic m);
    exp_state = {p[2] ? p[1] : m, nc[7] && done, 6'h00};
  endfunction
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h0000_4d78;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    starts = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {an_speed_100, an_full_duplex, mdix_resolved_mdi, an_fail, led_n} = 6'h2b;
    set_delay = 4'h1;
    set_cable = 12'h000;
    strap = 3'($random(seed));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    rd(8'h2c, v);
    chk(v, {strap, 5'h1f});
    rd(8'h2d, v);
    chk(v, 9'h000);
    rd(8'h31, v);
    chk({reg_rvalid, v}, 9'h100);
    $display("reset values done");
    for (i = 0; i < 12; i++) begin
      neg = 8'($random(seed));
      pc = 8'($random(seed));
      if (i < 2) begin
        neg = {8{i[0]}};
        pc = {8{~i[0]}};
      end
      {an_speed_100, an_full_duplex, mdix_resolved_mdi, an_fail, led_n} = 6'($random(seed));
      wr(8'h2c, neg);
      wr(8'h2d, pc);
      wr(8'h2b, ~neg);
      wr(8'h2e, ~neg);
      repeat (25) @(negedge clk);
      rd(8'h2c, v);
      chk(v, neg);
      rd(8'h2d, v);
      chk(v, pc);
      chk({an_enable, an_advertise}, {neg[7], neg[4:0]});
      chk({tx_disable, far_end_fault_disable, power_down, mdix_auto_disable, force_mdi, loopback},
        {pc[6], pc[4:0]});
      chk({pin_one, pin_zero}, pc[7] ? 2'h3 : led_n);
      chk({link_speed_100, link_full_duplex},
        exp_link(neg, an_complete, an_speed_100, an_full_duplex));
      rd(8'h2e, v);
      chk(v, exp_state(neg, pc, an_complete, mdix_resolved_mdi));
      rd(8'h2b, v);
      chk(v, 9'h000);
    end
    $display("register fields done");
    for (i = 0; i < 4; i++) begin
      set_cable = 12'($random(seed));
      set_cable[10:9] = 2'(i);
      set_delay = 4'(i * 4 + 1);
      wr(8'h2a, 8'h10);
      if (i > 0) begin
        wr(8'h2a, i[0] ? 8'h1a : 8'h00); // a second launch is refused, a clear does not stop the run
      end
      n = 0;
      v = 8'h10;
      while (v[4] && n < 40) begin
        rd(8'h2a, v);
        n = n + 1;
      end
      chk(v, {set_cable[11:9], 1'b0, i[0], 1'b1, i[0], set_cable[8]});
      chk(9'(starts), 9'(i + 1));
      chk({force_link, remote_loopback}, {2{i[0]}});
      rd(8'h2b, v);
      chk(v, set_cable[7:0]);
    end
    $display("cable tests done");
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd(8'h2b, v);
    chk(v, 9'h000);
    repeat (2) @(negedge clk);
    // software keeps the forced duplex low, as recommended for forced-mode partners
    wr(8'h2c, 8'hdf);
    @(negedge clk);
    chk({link_speed_100, link_full_duplex},
      exp_link(8'hdf, an_complete, an_speed_100, an_full_duplex));
    $display("second reset done");
    test_done();
  end
endmodule // tb
`default_nettype wire
